// file: pkg/serial_rx_message_framer_pkg.sv
// ================
// Operation
// RULE1: Idle start waits for idle ms of quiet line.
// RULE2: Idle search drops characters and reloads the timer.
// RULE3: Start char mode drops until a match, stored first.
// RULE4: Idle plus start char: a wrong char restarts idle search.
// RULE5: Break is low beyond a character; storing follows it.
// RULE6: Break plus start char: a wrong char restarts break search.
// RULE7: Idle start with zero idle time starts at once.
// RULE8: Then the message timer starts at the request.
// RULE9: End char is stored, then reception ends.
// RULE10: Inter-char timer restarts per char, ends when exceeded.
// RULE11: Message timer runs from start, ends when elapsed.
// RULE12: Reaching the maximum count ends reception.
// RULE13: A parity error ends reception if parity is on.
// RULE14: Software aborts by a request with go clear.
// RULE15: The first enabled end condition ends reception.
// RULE16: Software sets idle time above one character time.
// RULE17: Software sets inter-char timeout above a character.
// RULE18: Software sets message timeout near 1.5 times the longest message.
// RULE19: Maximum count is one byte, one to 255.
// RULE20: On ending, a status flag names the cause.
// RULE21: The go bit is sampled at each receive request.
// RULE22: A millisecond tick comes from the system clock.
// RULE23: Count restarts at each start; final count reported.
package serial_rx_message_framer_pkg;

  // ================
  // Register byte offsets
  localparam logic [10:0] OFS_CTRL     = 11'h000;  // rx_control_a
  localparam logic [10:0] OFS_START    = 11'h004;  // start_char_val_a
  localparam logic [10:0] OFS_END      = 11'h008;  // end_char_val_a
  localparam logic [10:0] OFS_IDLE     = 11'h00C;  // idle_time_ms_a
  localparam logic [10:0] OFS_TIMEOUT  = 11'h010;  // timeout_ms_a
  localparam logic [10:0] OFS_MAXCNT   = 11'h014;  // max_count_a
  localparam logic [10:0] OFS_PORTCFG  = 11'h018;  // port_config_a
  localparam logic [10:0] OFS_REQUEST  = 11'h01C;  // receive_request
  localparam logic [10:0] OFS_STATUS   = 11'h020;
  localparam logic [10:0] OFS_BUF_BASE = 11'h400;

  // ================
  // Control byte fields
  localparam int CTL_GO     = 7;
  localparam int CTL_SC     = 6;
  localparam int CTL_EC     = 5;
  localparam int CTL_IL     = 4;
  localparam int CTL_CM     = 3;
  localparam int CTL_TMR    = 2;
  localparam int CTL_BK     = 1;
  // Port config fields
  localparam int PCFG_PAR_EN  = 0;
  localparam int PCFG_BIT_LSB = 16;
  // Status fields
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_CAUSE0  = 2;   // cause bits 6:2
  localparam int ST_CNT_LSB = 8;
  // Cause vector positions
  localparam int CS_ENDCH  = 0;
  localparam int CS_TIMER  = 1;
  localparam int CS_COUNT  = 2;
  localparam int CS_PARITY = 3;
  localparam int CS_USER   = 4;

  // ================
  // Reset values
  localparam logic [7:0]  RST_CTRL    = 8'h00;
  localparam logic [7:0]  RST_MAXCNT  = 8'hFF;
  localparam logic [31:0] RST_PORTCFG = 32'h0364_0000;  // 868 cycles a bit

  // ================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CHAR_BITS = 11;   // start, 8 data, parity, stop
  localparam int BUF_DEPTH = 255;

endpackage : serial_rx_message_framer_pkg

// file: sim/remote_sender.sv
// ================
// Remote serial device model
module remote_sender (
  input  wire logic  clk_sys,        // System clock
  output logic       rx_line,        // Line level
  output logic       rx_char_valid,  // Char strobe
  output logic [7:0] rx_char,        // Char value
  output logic       rx_par_err      // Parity flag
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle mark line at start
  initial begin
    rx_line = 1'b1;
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    rx_par_err = 1'b0;
  end
  // One character; stale data inverted so it never matches
  task send(input logic [7:0] c, input logic pe);
    rx_line <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rx_line <= 1'b1;
    rx_char_valid <= 1'b1;
    rx_char <= c;
    rx_par_err <= pe;
    @(posedge clk_sys);
    rx_char_valid <= 1'b0;
    rx_char <= ~c;
    rx_par_err <= ~pe;
  endtask
  // Line held low for n cycles
  task brk(input int n);
    rx_line <= 1'b0;
    repeat (n) @(posedge clk_sys);
    rx_line <= 1'b1;
    @(posedge clk_sys);
  endtask
endmodule // remote_sender

// file: sim/serial_rx_message_framer_sva.sv
// ================
// Port checker for the receive framer
module serial_rx_message_framer_chk (
  input wire logic        clk_sys,          // Clock
  input wire logic        sys_rst,          // Reset
  input wire logic [10:0] avm_address,      // Address
  input wire logic        avm_read,         // Read
  input wire logic        avm_write,        // Write
  input wire logic [31:0] avm_writedata,    // Write data
  input wire logic [3:0]  avm_byteenable,   // Lanes
  input wire logic [31:0] avm_readdata,     // Read data
  input wire logic        avm_waitrequest,  // Wait
  input wire logic        rx_line,          // Line
  input wire logic        rx_char_valid,    // Strobe
  input wire logic [7:0]  rx_char,          // Char
  input wire logic        rx_par_err,       // Parity flag
  input wire logic        rx_busy,          // Busy
  input wire logic        rx_done           // Done
);
  logic go_r, par_r, req_ok, req_d1_r, req_d2_r;
  // Accepted receive request
  assign req_ok = avm_write && !avm_waitrequest && avm_address == serial_rx_message_framer_pkg::OFS_REQUEST;
  // Shadow go and parity bits; busy may lag a request by two edges
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      go_r <= 1'b0;
      par_r <= 1'b0;
      req_d1_r <= 1'b0;
      req_d2_r <= 1'b0;
    end else begin
      req_d1_r <= req_ok;
      req_d2_r <= req_d1_r;
      if (avm_write && !avm_waitrequest && avm_byteenable[0]) begin
        if (avm_address == serial_rx_message_framer_pkg::OFS_CTRL) go_r <= avm_writedata[7];
        if (avm_address == serial_rx_message_framer_pkg::OFS_PORTCFG) par_r <= avm_writedata[0];
      end
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_bus_answer: assert property ($rose(avm_read || avm_write) |=> !avm_waitrequest)
    else $error("late answer");
  chk_answer_short: assert property (!avm_waitrequest |=> avm_waitrequest)
    else $error("long answer");
  chk_go_busy: assert property (req_ok && go_r |-> ##[1:3] rx_busy)
    else $error("no start");
  chk_abort_end: assert property (req_ok && !go_r && rx_busy |-> ##[1:2] rx_done)
    else $error("no abort end");
  chk_parity_end: assert property (rx_busy && par_r && rx_char_valid && rx_par_err |-> ##[1:2] rx_done)
    else $error("no parity end");
  chk_done_pulse: assert property (rx_done |=> !rx_done)
    else $error("long done");
  chk_end_flag: assert property ($fell(rx_busy) |-> rx_done)
    else $error("end without done");
  chk_idle_stays: assert property (!rx_busy && !req_ok && !req_d1_r && !req_d2_r |=> !rx_busy)
    else $error("stray busy");
  chk_byte_upper: assert property (avm_read && !avm_waitrequest
    && avm_address == serial_rx_message_framer_pkg::OFS_MAXCNT |-> avm_readdata[31:8] == 24'h000000)
    else $error("upper bits set");
  cover property (req_ok && !go_r && rx_busy);
  cover property (rx_busy && rx_char_valid && rx_par_err);
  cover property ($fell(rx_busy));
endmodule // serial_rx_message_framer_chk

bind serial_rx_message_framer serial_rx_message_framer_chk chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .avm_address(avm_address), .avm_read(avm_read), .avm_write(avm_write), .avm_writedata(avm_writedata),
  .avm_byteenable(avm_byteenable), .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
  .rx_line(rx_line), .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_par_err(rx_par_err),
  .rx_busy(rx_busy), .rx_done(rx_done));

// file: sim/serial_rx_message_framer_tb.sv
// ================
// Testbench
module serial_rx_message_framer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, sys_rst, avm_read, avm_write, avm_waitrequest;
  logic        rx_line, rx_char_valid, rx_par_err, rx_busy, rx_done;
  logic [10:0] avm_address;
  logic [31:0] avm_writedata, avm_readdata, rd;
  logic [3:0]  avm_byteenable;
  logic [7:0]  rx_char, exp_q[$];
  int          mismatches, n_tests, cyc, seed, wait_n, n;

  serial_rx_message_framer #(.TICK_CYCLES(20), .BUF_DEPTH(255)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avm_address(avm_address), .avm_read(avm_read), .avm_write(avm_write), .avm_writedata(avm_writedata),
    .avm_byteenable(avm_byteenable), .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
    .rx_line(rx_line), .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_par_err(rx_par_err),
    .rx_busy(rx_busy), .rx_done(rx_done));
  remote_sender partner_u (.clk_sys(clk_sys), .rx_line(rx_line), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .rx_par_err(rx_par_err));

  // ================
  // Clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ================
  // Helpers
  task print_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus cycle held until waitrequest is seen low
  task bus(input logic w, input logic [10:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avm_address <= a;
    avm_writedata <= d;
    avm_write <= w;
    avm_read <= !w;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avm_waitrequest !== 1'b0 && k < 50);
    rd = avm_readdata;
    if (k >= 50) mismatches++;
    avm_write <= 1'b0;
    avm_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  function logic [7:0] rnd();
    logic [7:0] r;
    r = 8'($random(seed));
    if (r == 8'h3A || r == 8'h0D) r = 8'h55;  // Keep clear of start and end chars
    return r;
  endfunction
  task start(input logic [7:0] ctl, input logic [15:0] idle, input logic [15:0] tmo, input logic [7:0] mx);
    exp_q.delete();
    bus(1'b1, serial_rx_message_framer_pkg::OFS_IDLE, {16'h0000, idle});
    bus(1'b1, serial_rx_message_framer_pkg::OFS_TIMEOUT, {16'h0000, tmo});
    bus(1'b1, serial_rx_message_framer_pkg::OFS_MAXCNT, {24'h000000, mx});
    bus(1'b1, serial_rx_message_framer_pkg::OFS_CTRL, {24'h000000, ctl});
    bus(1'b1, serial_rx_message_framer_pkg::OFS_REQUEST, 32'h00000000);
    @(posedge clk_sys);
  endtask
  task tx(input logic [7:0] c, input bit keep, input logic pe);
    partner_u.send(c, pe);
    if (keep) exp_q.push_back(c);
  endtask
  // Wait for end; check status and buffer
  task fin(input int cause = serial_rx_message_framer_pkg::CS_COUNT);
    wait_n = 0;
    while (rx_busy !== 1'b0 && wait_n < 3000) begin
      @(posedge clk_sys);
      wait_n++;
    end
    if (wait_n >= 3000) mismatches++;
    bus(1'b0, serial_rx_message_framer_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h0000FFFF, {16'h0000, 8'(exp_q.size()), 6'(32'd1 << cause), 2'b10});
    for (int i = 0; i < exp_q.size(); i++) begin
      bus(1'b0, serial_rx_message_framer_pkg::OFS_BUF_BASE + 11'(4 * i), 32'h0);
      chk(rd, {24'h000000, exp_q[i]});
    end
  endtask

  // ================
  // Main sequence
  initial begin
    seed = 32'hE929;
    sys_rst = 1'b1;
    avm_read = 1'b0;
    avm_write = 1'b0;
    avm_address = 11'h000;
    avm_writedata = 32'h0;
    avm_byteenable = 4'hF;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    bus(1'b0, serial_rx_message_framer_pkg::OFS_MAXCNT, 32'h0);
    chk(rd, 32'h000000FF);
    bus(1'b0, serial_rx_message_framer_pkg::OFS_PORTCFG, 32'h0);
    chk(rd, 32'h03640000);
    bus(1'b0, 11'h024, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, serial_rx_message_framer_pkg::OFS_START, 32'h3A);
    bus(1'b1, serial_rx_message_framer_pkg::OFS_END, 32'h0D);
    // Four clocks a bit, so a break is over 44 cycles low
    bus(1'b1, serial_rx_message_framer_pkg::OFS_PORTCFG, 32'h00040000);
    start(8'h90, 0, 0, 3); repeat (3) tx(rnd(), 1, 0);
    fin();
    start(8'hC0, 0, 0, 2); tx(rnd(), 0, 0); tx(8'h3A, 1, 0); tx(rnd(), 1, 0);
    fin();
    start(8'hB0, 0, 0, 10); tx(rnd(), 1, 0); tx(rnd(), 1, 0); tx(8'h0D, 1, 0);
    fin(serial_rx_message_framer_pkg::CS_ENDCH);
    start(8'h90, 3, 0, 2); tx(rnd(), 0, 0); repeat (8) @(posedge clk_sys); tx(rnd(), 0, 0);
    repeat (80) @(posedge clk_sys); tx(rnd(), 1, 0); tx(rnd(), 1, 0);
    fin();
    start(8'hD0, 3, 0, 2); repeat (80) @(posedge clk_sys); tx(rnd(), 0, 0); tx(8'h3A, 0, 0);
    repeat (80) @(posedge clk_sys); tx(8'h3A, 1, 0); tx(rnd(), 1, 0);
    fin();
    start(8'h82, 0, 0, 2); tx(rnd(), 0, 0); partner_u.brk(60); tx(rnd(), 1, 0); tx(rnd(), 1, 0);
    fin();
    start(8'hC2, 0, 0, 2); partner_u.brk(60); tx(rnd(), 0, 0); tx(8'h3A, 0, 0);
    partner_u.brk(60); tx(8'h3A, 1, 0); tx(rnd(), 1, 0);
    fin();
    start(8'h94, 0, 2, 10); tx(rnd(), 1, 0); repeat (15) @(posedge clk_sys); tx(rnd(), 1, 0);
    fin(serial_rx_message_framer_pkg::CS_TIMER);
    start(8'h9C, 0, 2, 10);
    fin(serial_rx_message_framer_pkg::CS_TIMER);
    chk(32'(wait_n >= 15 && wait_n <= 45), 32'h1);
    bus(1'b1, serial_rx_message_framer_pkg::OFS_PORTCFG, 32'h00040001);
    start(8'h90, 0, 0, 10); tx(rnd(), 1, 0); tx(rnd(), 1, 1);
    fin(serial_rx_message_framer_pkg::CS_PARITY);
    start(8'h90, 0, 0, 10); tx(rnd(), 1, 0);
    bus(1'b1, serial_rx_message_framer_pkg::OFS_CTRL, 32'h0); bus(1'b1, serial_rx_message_framer_pkg::OFS_REQUEST, 32'h0);
    fin(serial_rx_message_framer_pkg::CS_USER);
    // Random lengths, then the full buffer
    repeat (4) begin
      n = 1 + int'($unsigned($random(seed)) % 6);
      start(8'h90, 0, 0, 8'(n)); repeat (n) tx(rnd(), 1, 0);
      fin();
    end
    start(8'h90, 0, 0, 255); repeat (255) tx(rnd(), 1, 0);
    fin();
    print_verdict();
  end
endmodule // serial_rx_message_framer_tb

// file: src/break_detector.sv
// ================
// Break detector: line low longer than one character
module break_detector (
  input  wire logic        clk_sys,     // System clock
  input  wire logic        sys_rst,     // Sync reset, high
  input  wire logic        rx_line,     // Serial line level
  input  wire logic [15:0] bit_cycles,  // Clocks per bit
  output logic             brk          // Pulse once per break
);
  logic [20:0] low_r;
  logic [20:0] limit;

  // Strictly greater than a full character time
  assign limit = 21'(bit_cycles) * 21'(serial_rx_message_framer_pkg::CHAR_BITS);

  // RULE5 low time measure
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      low_r <= 21'h00_0000;
      brk   <= 1'b0;
    end else if (rx_line) begin
      low_r <= 21'h00_0000;
      brk   <= 1'b0;
    end else begin
      // Saturates so one long break gives one pulse
      if (low_r <= limit) begin
        low_r <= low_r + 21'h00_0001;
      end
      brk <= (low_r == limit);
    end
  end
endmodule // break_detector

// file: src/ms_tick_gen.sv
// ================
// Millisecond tick
module ms_tick_gen #(
  parameter int TICK_CYCLES = serial_rx_message_framer_pkg::TICK_CYCLES
) (
  input  wire logic clk_sys,  // System clock
  input  wire logic sys_rst,  // Sync reset, high
  output logic      tick      // One-cycle pulse each ms
);
  logic [31:0] cnt_r;

  // RULE22 free running divider
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (cnt_r == 32'(TICK_CYCLES - 1)) begin
      cnt_r <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end
endmodule // ms_tick_gen

// file: src/serial_rx_message_framer.sv
// ================
// Receive message framer, Avalon-MM slave
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
module serial_rx_message_framer #(
  parameter int TICK_CYCLES = serial_rx_message_framer_pkg::TICK_CYCLES,
  parameter int BUF_DEPTH   = serial_rx_message_framer_pkg::BUF_DEPTH
) (
  input  wire logic        clk_sys,          // System clock
  input  wire logic        sys_rst,          // Sync reset, high
  input  wire logic [10:0] avm_address,      // Byte address
  input  wire logic        avm_read,         // Read request
  input  wire logic        avm_write,        // Write request
  input  wire logic [31:0] avm_writedata,    // Write data
  input  wire logic [3:0]  avm_byteenable,   // Byte lanes
  output logic [31:0]      avm_readdata,     // Read data
  output logic             avm_waitrequest,  // Low on answer
  input  wire logic        rx_line,          // Serial line level
  input  wire logic        rx_char_valid,    // Char done, at stop bit
  input  wire logic [7:0]  rx_char,          // Received char
  input  wire logic        rx_par_err,       // Parity error on char
  output logic             rx_busy,          // Reception active
  output logic             rx_done           // Pulse at end
);

  // ================
  // State
  typedef enum logic [4:0] {
    S_OFF   = 5'b00001,
    S_IDLE  = 5'b00010,
    S_BRK   = 5'b00100,
    S_SCHAR = 5'b01000,
    S_RECV  = 5'b10000
  } fsm_t;

  typedef struct packed {
    fsm_t                        st;
    logic [7:0]                  ctrl;
    logic [7:0]                  start_ch;
    logic [7:0]                  end_ch;
    logic [15:0]                 idle_ms;
    logic [15:0]                 tmo_ms;
    logic [7:0]                  max_cnt;
    logic [31:0]                 port_cfg;
    logic [15:0]                 idle_left;
    logic [15:0]                 elapsed;
    logic [7:0]                  count;
    logic [4:0]                  cause;
    logic                        fin;
    logic                        done;
    logic                        busy;
    logic                        waitreq;
    logic [31:0]                 rdata;
    logic [BUF_DEPTH-1:0][7:0]   mem;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic tick;
  logic brk;

  // ================
  // Helpers
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Timer expiry: message kind on reach, inter-char kind on exceed
  function automatic logic tmr_expired(input logic [15:0] el, input logic [15:0] lim, input logic msg);
    return msg ? (el >= lim) : (el > lim);
  endfunction

  // ================
  // Sub-blocks
  ms_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .tick    (tick)
  );

  break_detector u_brk (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .rx_line    (rx_line),
    .bit_cycles (st_r.port_cfg[serial_rx_message_framer_pkg::PCFG_BIT_LSB +: 16]),
    .brk        (brk)
  );

  // ================
  // Next state
  always_comb begin
    logic        hit_wr;
    logic        store;
    logic        il;
    logic        sc;
    logic        bk;
    logic        par_en;
    logic [8:0]  cnt_inc;
    logic [15:0] el_inc;
    logic [7:0]  idx;
    logic [31:0] rd;
    logic [31:0] wr;

    st_nxt  = st_r;
    hit_wr  = avm_write && !st_r.waitreq;
    store   = 1'b0;
    il      = st_r.ctrl[serial_rx_message_framer_pkg::CTL_IL];
    sc      = st_r.ctrl[serial_rx_message_framer_pkg::CTL_SC];
    bk      = st_r.ctrl[serial_rx_message_framer_pkg::CTL_BK];
    par_en  = st_r.port_cfg[serial_rx_message_framer_pkg::PCFG_PAR_EN];
    cnt_inc = {1'b0, st_r.count} + 9'h001;
    el_inc  = (st_r.elapsed == 16'hFFFF) ? st_r.elapsed : st_r.elapsed + 16'h0001;
    idx     = avm_address[9:2];
    rd      = 32'h0000_0000;
    wr      = 32'h0000_0000;
    st_nxt.fin = 1'b0;

    // Read mux; unmapped reads answer zero
    case (avm_address)
      serial_rx_message_framer_pkg::OFS_CTRL:    rd = {24'h00_0000, st_r.ctrl};
      serial_rx_message_framer_pkg::OFS_START:   rd = {24'h00_0000, st_r.start_ch};
      serial_rx_message_framer_pkg::OFS_END:     rd = {24'h00_0000, st_r.end_ch};
      serial_rx_message_framer_pkg::OFS_IDLE:    rd = {16'h0000, st_r.idle_ms};
      serial_rx_message_framer_pkg::OFS_TIMEOUT: rd = {16'h0000, st_r.tmo_ms};
      serial_rx_message_framer_pkg::OFS_MAXCNT:  rd = {24'h00_0000, st_r.max_cnt};
      serial_rx_message_framer_pkg::OFS_PORTCFG: rd = st_r.port_cfg;
      // RULE20 cause flags and RULE23 final count
      serial_rx_message_framer_pkg::OFS_STATUS:  rd = {16'h0000, st_r.count, 1'b0, st_r.cause,
                                                       st_r.fin | st_r.done, st_r.busy};
      default: begin
        if (avm_address[10] && avm_address[1:0] == 2'b00 && 32'(idx) < BUF_DEPTH) begin
          rd = {24'h00_0000, st_r.mem[idx]};
        end
      end
    endcase

    // Bus answer one cycle after the request appears
    st_nxt.waitreq = 1'b1;
    if ((avm_read || avm_write) && st_r.waitreq) begin
      st_nxt.waitreq = 1'b0;
      st_nxt.rdata   = rd;
    end

    // ================
    // Line side sequencing
    case (st_r.st)
      S_IDLE: begin
        if (rx_char_valid) begin
          // RULE2 drop and reload
          st_nxt.idle_left = st_r.idle_ms;
        end else if (tick) begin
          // RULE1 quiet time reached
          if (st_r.idle_left <= 16'h0001) begin
            if (sc) begin
              st_nxt.st = S_SCHAR;
            end else begin
              st_nxt.st      = S_RECV;
              st_nxt.elapsed = 16'h0000;
            end
          end else begin
            st_nxt.idle_left = st_r.idle_left - 16'h0001;
          end
        end
      end
      S_BRK: begin
        // RULE5 break starts message
        if (brk) begin
          if (sc) begin
            st_nxt.st = S_SCHAR;
          end else begin
            st_nxt.st      = S_RECV;
            st_nxt.elapsed = 16'h0000;
          end
        end
      end
      S_SCHAR: begin
        if (rx_char_valid) begin
          // RULE3 start char stored first
          if (rx_char == st_r.start_ch) begin
            store          = 1'b1;
            st_nxt.st      = S_RECV;
            st_nxt.elapsed = 16'h0000;
          end else if (il) begin
            // RULE4 back to idle search
            st_nxt.st        = S_IDLE;
            st_nxt.idle_left = st_r.idle_ms;
          end else if (bk) begin
            // RULE6 back to break search
            st_nxt.st = S_BRK;
          end
        end
      end
      S_RECV: begin
        if (rx_char_valid) begin
          store = 1'b1;
          // RULE10 restart inter-char timer
          if (!st_r.ctrl[serial_rx_message_framer_pkg::CTL_CM]) begin
            st_nxt.elapsed = 16'h0000;
          end
          // RULE9 end char stored then stop
          if (st_r.ctrl[serial_rx_message_framer_pkg::CTL_EC] && rx_char == st_r.end_ch) begin
            st_nxt.cause[serial_rx_message_framer_pkg::CS_ENDCH] = 1'b1;
            st_nxt.fin = 1'b1;
          end
        end else if (tick) begin
          st_nxt.elapsed = el_inc;
          // RULE11 message timer, RULE10 inter-char timer
          if (st_r.ctrl[serial_rx_message_framer_pkg::CTL_TMR] &&
              tmr_expired(el_inc, st_r.tmo_ms, st_r.ctrl[serial_rx_message_framer_pkg::CTL_CM])) begin
            st_nxt.cause[serial_rx_message_framer_pkg::CS_TIMER] = 1'b1;
            st_nxt.fin = 1'b1;
          end
        end
      end
      default: begin
      end
    endcase

    // Common store path
    if (store) begin
      st_nxt.mem[st_r.count] = rx_char;
      st_nxt.count           = cnt_inc[7:0];
      // RULE12 count limit keeps storage in buffer
      if (cnt_inc >= {1'b0, st_r.max_cnt}) begin
        st_nxt.cause[serial_rx_message_framer_pkg::CS_COUNT] = 1'b1;
        st_nxt.fin = 1'b1;
      end
    end

    // RULE13 parity error ends an active reception when parity is enabled
    if (par_en && rx_char_valid && rx_par_err && st_r.st != S_OFF) begin
      st_nxt.cause[serial_rx_message_framer_pkg::CS_PARITY] = 1'b1;
      st_nxt.fin = 1'b1;
    end

    // RULE15 first enabled end condition wins
    if (st_nxt.fin) begin
      st_nxt.st   = S_OFF;
      st_nxt.busy = 1'b0;
    end

    // ================
    // Register writes, taken at the answer edge
    if (hit_wr) begin
      case (avm_address)
        serial_rx_message_framer_pkg::OFS_CTRL: begin
          wr = be_merge({24'h00_0000, st_r.ctrl}, avm_writedata, avm_byteenable);
          st_nxt.ctrl = {wr[7:1], 1'b0};
        end
        serial_rx_message_framer_pkg::OFS_START: begin
          wr = be_merge({24'h00_0000, st_r.start_ch}, avm_writedata, avm_byteenable);
          st_nxt.start_ch = wr[7:0];
        end
        serial_rx_message_framer_pkg::OFS_END: begin
          wr = be_merge({24'h00_0000, st_r.end_ch}, avm_writedata, avm_byteenable);
          st_nxt.end_ch = wr[7:0];
        end
        serial_rx_message_framer_pkg::OFS_IDLE: begin
          wr = be_merge({16'h0000, st_r.idle_ms}, avm_writedata, avm_byteenable);
          st_nxt.idle_ms = wr[15:0];
        end
        serial_rx_message_framer_pkg::OFS_TIMEOUT: begin
          wr = be_merge({16'h0000, st_r.tmo_ms}, avm_writedata, avm_byteenable);
          st_nxt.tmo_ms = wr[15:0];
        end
        // RULE19 byte-wide maximum count
        serial_rx_message_framer_pkg::OFS_MAXCNT: begin
          wr = be_merge({24'h00_0000, st_r.max_cnt}, avm_writedata, avm_byteenable);
          st_nxt.max_cnt = wr[7:0];
        end
        serial_rx_message_framer_pkg::OFS_PORTCFG: begin
          st_nxt.port_cfg = be_merge(st_r.port_cfg, avm_writedata, avm_byteenable);
        end
        serial_rx_message_framer_pkg::OFS_REQUEST: begin
          // RULE21 go bit sampled per request
          if (st_r.ctrl[serial_rx_message_framer_pkg::CTL_GO]) begin
            // RULE23 count restarts
            st_nxt.count     = 8'h00;
            st_nxt.cause     = 5'h00;
            st_nxt.fin       = 1'b0;
            st_nxt.busy      = 1'b1;
            st_nxt.elapsed   = 16'h0000;
            st_nxt.idle_left = st_r.idle_ms;
            if (il && st_r.idle_ms == 16'h0000) begin
              // RULE7 immediate start, RULE8 message timer runs now
              st_nxt.st = S_RECV;
            end else if (il) begin
              st_nxt.st = S_IDLE;
            end else if (bk) begin
              st_nxt.st = S_BRK;
            end else if (sc) begin
              st_nxt.st = S_SCHAR;
            end else begin
              st_nxt.st = S_RECV;
            end
          end else if (st_r.st != S_OFF) begin
            // RULE14 user abort ends at once
            st_nxt.st   = S_OFF;
            st_nxt.busy = 1'b0;
            st_nxt.cause[serial_rx_message_framer_pkg::CS_USER] = 1'b1;
            st_nxt.fin  = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Done pulse follows the end of reception; sticky copy is fin|done
    st_nxt.done = st_nxt.fin | (st_r.done & !(hit_wr && avm_address == serial_rx_message_framer_pkg::OFS_REQUEST
                                              && st_r.ctrl[serial_rx_message_framer_pkg::CTL_GO]));
  end

  // ================
  // Register the state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r          <= '0;
      st_r.st       <= S_OFF;
      st_r.ctrl     <= serial_rx_message_framer_pkg::RST_CTRL;
      st_r.max_cnt  <= serial_rx_message_framer_pkg::RST_MAXCNT;
      st_r.port_cfg <= serial_rx_message_framer_pkg::RST_PORTCFG;
      st_r.waitreq  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign avm_readdata    = st_r.rdata;
  assign avm_waitrequest = st_r.waitreq;
  assign rx_busy         = st_r.busy;
  assign rx_done         = st_r.fin;

endmodule // serial_rx_message_framer
